// [sri_exec.v]
// executer for push, pop, return, clear-carry and rotate instructions
`default_nettype none
`include "sri_defines.vh"

module sri_exec #(
  parameter AW = 12
) (
  input wire clk, // system clock, 125 mhz
  input wire rst_b, // asynchronous reset, active low
  input wire ce, // clock enable, freezes all state but the reset synchronizer when low
  input wire [7:0] pm_rdata, // program byte at pm_addr, same cycle
  input wire [7:0] rp, // working register pointer
  output reg [15:0] pm_addr, // program counter
  output reg [AW-1:0] stack_pointer, // stack pointer
  output reg [7:0] flags, // c z s v d h flags, low two unused
  output reg instr_done, // pulse when an instruction ends
  output reg illegal_op // pulse on an unsupported opcode
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  reg rst_meta_r;
  reg rst_n_r;

  // assert at once, release through two flops
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ****************************************************************
  // state and helpers
  // ****************************************************************
  localparam [3:0] ST_FETCH = 4'b0001;
  localparam [3:0] ST_OPND1 = 4'b0010;
  localparam [3:0] ST_OPND2 = 4'b0100;
  localparam [3:0] ST_EXEC = 4'b1000;

  reg [3:0] state_r;
  reg pre_r;
  reg imf_r;
  reg [7:0] op_r;
  reg [7:0] opnd1_r;
  reg [7:0] opnd2_r;
  reg [1:0] extra_r;
  reg [2:0] ncyc_r;
  reg [2:0] step_r;
  reg [AW-1:0] ea_r;
  reg [7:0] hi_r;
  reg [7:0] lo_r;
  wire [7:0] rd_data;

  // register address: escape nibble picks a working register
  function [11:0] map8;
    input [7:0] a;
    input [7:0] p;
    begin
      if (a[7:4] == `SRI_ESC_NIB)
        map8 = {p[3:0], p[7:4], a[3:0]};
      else
        map8 = {p[3:0], a};
    end
  endfunction

  // 12-bit address, double escape nibble also maps a working register
  function [11:0] map12;
    input [11:0] a;
    input [7:0] p;
    begin
      if (a[11:4] == {`SRI_ESC_NIB, `SRI_ESC_NIB})
        map12 = {p[3:0], p[7:4], a[3:0]};
      else
        map12 = a;
    end
  endfunction

  // rotate result with new carry on top
  function [8:0] rot8;
    input [7:0] op;
    input [7:0] d;
    input c;
    begin
      case (op[7:4])
        4'h9: rot8 = {d[7], d[6:0], d[7]};
        4'h1: rot8 = {d[7], d[6:0], c};
        4'he: rot8 = {d[0], d[0], d[7:1]};
        4'hc: rot8 = {d[0], c, d[7:1]};
        default: rot8 = {c, d};
      endcase
    end
  endfunction

  wire is_rot = (op_r == `SRI_OP_RL_R) || (op_r == `SRI_OP_RL_IR) || (op_r == `SRI_OP_RLC_R) ||
    (op_r == `SRI_OP_RLC_IR) || (op_r == `SRI_OP_RR_R) || (op_r == `SRI_OP_RR_IR) ||
    (op_r == `SRI_OP_RRC_R) || (op_r == `SRI_OP_RRC_IR);
  wire is_push = (op_r == `SRI_OP_PUSH_R) || (op_r == `SRI_OP_PUSH_IR);
  wire last = (step_r == (ncyc_r - 3'd1));
  wire [AW-1:0] reg_ea = map8(opnd1_r, rp);
  wire [AW-1:0] ext_ea = map12({opnd1_r, opnd2_r[7:4]}, rp);
  wire [AW-1:0] sp_dec = stack_pointer - {{(AW-1){1'b0}}, 1'b1};
  wire [AW-1:0] sp_inc = stack_pointer + {{(AW-1){1'b0}}, 1'b1};
  wire [AW-1:0] sp_inc2 = stack_pointer + {{(AW-2){1'b0}}, 2'b10};
  wire [8:0] rot_res = rot8(op_r, rd_data, flags[`SRI_FLAG_C]);

  // ****************************************************************
  // opcode decode: extra bytes and execute cycles
  // ****************************************************************
  reg dec_ok;
  reg [1:0] dec_extra;
  reg [2:0] dec_ncyc;

  // pointed forms carry one more memory read, hence one more cycle
  always @*
  begin
    dec_ok = 1'b1;
    dec_extra = 2'd1;
    dec_ncyc = `SRI_CYC_2;
    if (pre_r)
    begin
      if (pm_rdata != `SRI_OP_PUSH_R)
        dec_ok = 1'b0;
    end
    else
    begin
      case (pm_rdata)
        `SRI_OP_PUSH_R, `SRI_OP_RL_R, `SRI_OP_RLC_R, `SRI_OP_RR_R, `SRI_OP_RRC_R:
          dec_ncyc = `SRI_CYC_2;
        `SRI_OP_PUSH_IR, `SRI_OP_RL_IR, `SRI_OP_RLC_IR, `SRI_OP_RR_IR, `SRI_OP_RRC_IR:
          dec_ncyc = `SRI_CYC_3;
        `SRI_OP_STACK_STORE_EXTENDED, `SRI_OP_STACK_LOAD_EXTENDED:
          dec_extra = 2'd2;
        `SRI_OP_RET:
        begin
          dec_extra = 2'd0;
          dec_ncyc = `SRI_CYC_4;
        end
        `SRI_OP_RCF:
          dec_extra = 2'd0;
        default:
          dec_ok = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // data space access per execute step
  // ****************************************************************
  reg [AW-1:0] ram_raddr;
  reg ram_we;
  reg [AW-1:0] ram_waddr;
  reg [7:0] ram_wdata;

  // every write lands on the last step, where the read result is never used
  always @*
  begin
    ram_raddr = reg_ea;
    ram_we = 1'b0;
    ram_waddr = reg_ea;
    ram_wdata = rd_data;
    if (state_r == ST_EXEC)
    begin
      if (is_rot)
      begin
        if (op_r[0] && step_r == 3'd1)
          ram_raddr = map8(rd_data, rp);
        if (last)
        begin
          ram_we = 1'b1;
          ram_waddr = op_r[0] ? ea_r : reg_ea;
          ram_wdata = rot_res[7:0];
        end
      end
      else if (is_push)
      begin
        if (op_r[0] && step_r == 3'd1)
          ram_raddr = map8(rd_data, rp);
        if (last)
        begin
          ram_we = 1'b1;
          ram_waddr = sp_dec;
          ram_wdata = imf_r ? opnd1_r : rd_data;
        end
      end
      else if (op_r == `SRI_OP_STACK_STORE_EXTENDED)
      begin
        ram_raddr = ext_ea;
        if (last)
        begin
          ram_we = 1'b1;
          ram_waddr = sp_dec;
        end
      end
      else if (op_r == `SRI_OP_STACK_LOAD_EXTENDED)
      begin
        ram_raddr = stack_pointer;
        if (last)
        begin
          ram_we = 1'b1;
          ram_waddr = ext_ea;
        end
      end
      else if (op_r == `SRI_OP_RET)
      begin
        ram_raddr = (step_r == 3'd0) ? stack_pointer : sp_inc;
      end
    end
  end

  sri_ram #(
    .AW(AW),
    .DW(8)
  ) u_ram (
    .clk(clk),
    .ce(ce),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(ram_raddr),
    .rdata(rd_data)
  );

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // a prefix byte is fetched as its own cycle and only arms the literal form
  always @(posedge clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= ST_FETCH;
      pre_r <= 1'b0;
      imf_r <= 1'b0;
      op_r <= 8'h00;
      opnd1_r <= 8'h00;
      opnd2_r <= 8'h00;
      extra_r <= 2'd0;
      ncyc_r <= `SRI_CYC_2;
      step_r <= 3'd0;
      ea_r <= {AW{1'b0}};
      hi_r <= 8'h00;
      lo_r <= 8'h00;
      pm_addr <= `SRI_PC_RESET;
      stack_pointer <= `SRI_SP_RESET;
      flags <= `SRI_FLAGS_RESET;
      instr_done <= 1'b0;
      illegal_op <= 1'b0;
    end
    else if (ce)
    begin
      instr_done <= 1'b0;
      illegal_op <= 1'b0;
      case (state_r)
        ST_FETCH:
        begin
          pm_addr <= pm_addr + 16'h0001;
          if (!pre_r && pm_rdata == `SRI_OP_PREFIX)
            pre_r <= 1'b1;
          else
          begin
            pre_r <= 1'b0;
            imf_r <= pre_r;
            op_r <= pm_rdata;
            ncyc_r <= dec_ncyc;
            extra_r <= dec_extra;
            step_r <= 3'd0;
            if (!dec_ok)
            begin
              illegal_op <= 1'b1; // unknown byte is skipped
              instr_done <= 1'b1;
            end
            else if (dec_extra != 2'd0)
              state_r <= ST_OPND1;
            else
              state_r <= ST_EXEC;
          end
        end
        ST_OPND1:
        begin
          pm_addr <= pm_addr + 16'h0001;
          opnd1_r <= pm_rdata;
          state_r <= (extra_r == 2'd2) ? ST_OPND2 : ST_EXEC;
        end
        ST_OPND2:
        begin
          pm_addr <= pm_addr + 16'h0001;
          opnd2_r <= pm_rdata;
          state_r <= ST_EXEC;
        end
        ST_EXEC:
        begin
          step_r <= step_r + 3'd1;
          if (step_r == 3'd1)
          begin
            ea_r <= map8(rd_data, rp);
            hi_r <= rd_data;
          end
          if (step_r == 3'd2)
            lo_r <= rd_data;
          if (op_r == `SRI_OP_RCF && step_r == 3'd0)
            flags[`SRI_FLAG_C] <= 1'b0;
          if (last)
          begin
            state_r <= ST_FETCH;
            instr_done <= 1'b1;
            if (is_rot)
            begin
              // d and h are left alone
              flags[`SRI_FLAG_C] <= rot_res[8];
              flags[`SRI_FLAG_Z] <= (rot_res[7:0] == 8'h00);
              flags[`SRI_FLAG_S] <= rot_res[7];
              flags[`SRI_FLAG_V] <= rot_res[7] ^ rd_data[7];
            end
            if (is_push || op_r == `SRI_OP_STACK_STORE_EXTENDED)
              stack_pointer <= sp_dec;
            if (op_r == `SRI_OP_STACK_LOAD_EXTENDED)
              stack_pointer <= sp_inc;
            if (op_r == `SRI_OP_RET)
            begin
              pm_addr <= {hi_r, lo_r};
              stack_pointer <= sp_inc2;
            end
          end
        end
        default:
          state_r <= ST_FETCH;
      endcase
    end
  end

endmodule // sri_exec

`default_nettype wire

// [sri_defines.vh]
// constants for the stack and rotate instruction executer
// What this block does
// - 8-bit register operand selects location 0-255 of the page in rp[3:0], or working register via escape.
// - extended pop copies byte at stack pointer to destination, then increments pointer.
// - push decrements stack pointer then stores source; register, pointed, literal forms.
// - extended push decrements stack pointer then stores 12-bit addressed source byte.
// - return loads program counter from stack, adds two, four cycles, flags kept.
// - rotate left through carry; register form two cycles, pointed three.
// - rotate right circular copies bit 0 into bit 7 and carry.
// - rotate right through carry moves bit 0 to carry, carry to bit 7.
// - rotates compute carry, zero, sign, overflow; decimal-adjust and half-carry kept.
`ifndef SRI_DEFINES_VH
`define SRI_DEFINES_VH

// ****************************************************************
// opcodes
// ****************************************************************
`define SRI_OP_PREFIX 8'h1f
`define SRI_OP_PUSH_R 8'h70
`define SRI_OP_PUSH_IR 8'h71
`define SRI_OP_STACK_STORE_EXTENDED 8'hc8
`define SRI_OP_STACK_LOAD_EXTENDED 8'hd8
`define SRI_OP_RCF 8'hcf
`define SRI_OP_RET 8'haf
`define SRI_OP_RL_R 8'h90
`define SRI_OP_RL_IR 8'h91
`define SRI_OP_RLC_R 8'h10
`define SRI_OP_RLC_IR 8'h11
`define SRI_OP_RR_R 8'he0
`define SRI_OP_RR_IR 8'he1
`define SRI_OP_RRC_R 8'hc0
`define SRI_OP_RRC_IR 8'hc1

// ****************************************************************
// addressing and flags
// ****************************************************************
`define SRI_ESC_NIB 4'he
`define SRI_FLAG_C 7
`define SRI_FLAG_Z 6
`define SRI_FLAG_S 5
`define SRI_FLAG_V 4
`define SRI_FLAG_D 3
`define SRI_FLAG_H 2

// ****************************************************************
// execute cycle counts and reset values
// ****************************************************************
`define SRI_CYC_2 3'd2
`define SRI_CYC_3 3'd3
`define SRI_CYC_4 3'd4
`define SRI_PC_RESET 16'h0000
`define SRI_SP_RESET 12'h000
`define SRI_FLAGS_RESET 8'h00

`endif

// [sri_ram.v]
// data space of the executer: one write port, one registered read port
`default_nettype none

module sri_ram #(
  parameter AW = 12,
  parameter DW = 8
) (
  input wire clk, // system clock
  input wire ce, // clock enable, freezes the memory
  input wire we, // write strobe
  input wire [AW-1:0] waddr, // write address
  input wire [DW-1:0] wdata, // write data
  input wire [AW-1:0] raddr, // read address
  output reg [DW-1:0] rdata // read data, one cycle after raddr
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // no reset on the array: contents are undefined until written
  always @(posedge clk)
  begin
    if (ce)
    begin
      if (we)
      begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end

endmodule // sri_ram

`default_nettype wire

// [sri_exec_chk.sv]
// port assertions for the stack and rotate executer
`default_nettype none

module sri_exec_chk #(
  parameter AW = 12
) (
  input wire clk, // system clock
  input wire rst_b, // reset, active low
  input wire ce, // clock enable
  input wire [7:0] pm_rdata, // fetched byte
  input wire [7:0] rp, // register pointer
  input wire [15:0] pm_addr, // program counter
  input wire [AW-1:0] stack_pointer, // stack pointer
  input wire [7:0] flags, // flag byte
  input wire instr_done, // end of instruction
  input wire illegal_op // unsupported opcode
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // opcode seen in the cycle that reports the previous end
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  // a frozen cycle stretches every window, so the timed checks are disabled while ce is low
  default disable iff (!rst_b || !ce);
  wire go_ret = instr_done && (pm_rdata == 8'haf);
  wire go_push = instr_done && (pm_rdata == 8'h70);
  wire go_pop = instr_done && (pm_rdata == 8'hd8);
  wire go_stack_store_extended = instr_done && (pm_rdata == 8'hc8);
  wire go_rot = instr_done && (pm_rdata inside {8'h10, 8'h90, 8'he0, 8'hc0});

  ret_len_a: assert property (go_ret |=> !instr_done [*4] ##1 instr_done)
    else $error("return length wrong");
  ret_sp_a: assert property (go_ret |-> ##5 stack_pointer == AW'($past(stack_pointer, 5) + 2)
    && flags == $past(flags, 5)) else $error("return pointer or flags wrong");
  push_sp_a: assert property (go_push |-> ##4 stack_pointer == AW'($past(stack_pointer, 4) - 1)
    && flags == $past(flags, 4)) else $error("push pointer or flags wrong");
  pop_sp_a: assert property (go_pop |-> ##5 stack_pointer == AW'($past(stack_pointer, 5) + 1)
    && flags == $past(flags, 5)) else $error("extended pop pointer wrong");
  stack_store_extended_sp_a: assert property (go_stack_store_extended |-> ##5 stack_pointer == AW'($past(stack_pointer, 5) - 1)
    && flags == $past(flags, 5)) else $error("extended push pointer wrong");
  carry_clr_a: assert property (instr_done && pm_rdata == 8'hcf |-> ##3
    flags == {1'b0, $past(flags[6:0], 3)}) else $error("clear carry wrong");
  rot_reg_a: assert property (instr_done && pm_rdata == 8'h10 |=> !instr_done [*3] ##1 instr_done)
    else $error("register rotate length wrong");
  rot_ptr_a: assert property (instr_done && pm_rdata == 8'h11 |=> !instr_done [*4] ##1 instr_done)
    else $error("pointed rotate length wrong");
  rot_keep_a: assert property (go_rot |-> ##4 flags[3:0] == $past(flags[3:0], 4))
    else $error("rotate touched kept flags");
  ce_hold_a: assert property (disable iff (!rst_b) !ce |=> $stable(pm_addr) && $stable(stack_pointer)
    && $stable(flags) && $stable(instr_done) && $stable(illegal_op)) else $error("state moved while ce low");
  ill_done_a: assert property (illegal_op |-> instr_done)
    else $error("illegal opcode without end pulse");

  // main scenarios reached
  cover property (go_ret);
  cover property (illegal_op);
  cover property (go_rot ##4 flags[6]);
  cover property (disable iff (!rst_b) !ce ##1 ce);
endmodule // sri_exec_chk

bind sri_exec sri_exec_chk #(.AW(AW)) i_sri_exec_chk (.clk(clk), .rst_b(rst_b), .ce(ce), .pm_rdata(pm_rdata),
  .rp(rp), .pm_addr(pm_addr), .stack_pointer(stack_pointer), .flags(flags), .instr_done(instr_done),
  .illegal_op(illegal_op));
`default_nettype wire

// [sri_prog_rom.sv]
// program memory model holding the bench's instruction stream
`default_nettype none

module sri_prog_rom (
  input wire [15:0] pm_addr, // program counter
  output logic [7:0] pm_rdata // byte at pm_addr, same cycle
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rom [0:255];
  logic [7:0] p1 [0:21];
  logic [7:0] p2 [0:27];
  integer i;

  // ****************************************************************
  // image: pushes and rotates at 00, pointed forms and pops at 81
  // ****************************************************************
  // filler is clear-carry so a runaway fetch cannot touch the stack
  initial
  begin
    p1 = '{8'h1f, 8'h70, 8'h81, 8'h70, 8'hef, 8'h10, 8'hff, 8'h10, 8'hff, 8'he0, 8'hef,
      8'hc0, 8'hff, 8'h90, 8'hff, 8'hcf, 8'h1f, 8'h70, 8'h00, 8'h1f, 8'h55, 8'haf};
    // the last extended push names its source through the double escape, so the return depends on it
    p2 = '{8'h1f, 8'h70, 8'hff, 8'h11, 8'hfe, 8'he1, 8'hfe, 8'hc1, 8'hfe, 8'h91, 8'hfe, 8'h1f, 8'h70, 8'h00,
      8'hc0, 8'hfd, 8'hd8, 8'hff, 8'hb0, 8'hc8, 8'hff, 8'he0, 8'h71, 8'hfe, 8'hc8, 8'hee, 8'hb0, 8'haf};
    for (i = 0; i < 256; i = i + 1)
      rom[i] = 8'hcf;
    for (i = 0; i < 22; i = i + 1)
      rom[i] = p1[i];
    for (i = 0; i < 28; i = i + 1)
      rom[8'h81 + i] = p2[i];
  end

  // upper program space reads back as clear-carry too
  assign pm_rdata = (pm_addr[15:8] == 8'h00) ? rom[pm_addr[7:0]] : 8'hcf;
endmodule // sri_prog_rom
`default_nettype wire

// [sri_exec_bench.sv]
// self-checking bench for the stack and rotate executer
`default_nettype none

module sri_exec_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk;
  logic rst_b;
  logic ce;
  logic [7:0] rp;
  wire [7:0] pm_rdata;
  wire [15:0] pm_addr;
  wire [11:0] stack_pointer;
  wire [7:0] flags;
  wire instr_done;
  wire illegal_op;
  integer n_errors;
  integer checks_done;

  sri_exec #(.AW(12)) i_sri_exec (.clk(clk), .rst_b(rst_b), .ce(ce), .pm_rdata(pm_rdata), .rp(rp),
    .pm_addr(pm_addr), .stack_pointer(stack_pointer), .flags(flags), .instr_done(instr_done),
    .illegal_op(illegal_op));
  sri_prog_rom i_sri_prog_rom (.pm_addr(pm_addr), .pm_rdata(pm_rdata));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // 125 mhz clock
  always #4 clk = ~clk;

  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // waits for the end pulse, bounded, then judges the machine state
  task step(input logic [15:0] pc, input logic [11:0] sp, input logic [7:0] fl, input logic ill);
    integer k;
    logic hit;
    hit = 1'b0;
    for (k = 0; k < 12 && !hit; k = k + 1)
    begin
      @(posedge clk);
      #1;
      hit = (instr_done === 1'b1);
    end
    chk("instr_done", {15'h0, hit}, 16'h0001);
    chk("pm_addr", pm_addr, pc);
    chk("stack_pointer", {4'h0, stack_pointer}, {4'h0, sp});
    chk("flags", {8'h0, flags}, {8'h0, fl});
    chk("illegal_op", {15'h0, illegal_op}, {15'h0, ill});
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_reset;
    repeat (10) @(posedge clk);
    #1;
    chk("pm_addr", pm_addr, 16'h0000);
    chk("stack_pointer", {4'h0, stack_pointer}, 16'h0000);
    chk("flags", {8'h0, flags}, 16'h0000);
    chk("instr_done", {15'h0, instr_done}, 16'h0000);
    chk("illegal_op", {15'h0, illegal_op}, 16'h0000);
    rst_b = 1'b1;
    $display("reset test done");
  endtask

  // literal and escaped pushes, the four register rotates, return
  task t_rotate_return;
    step(16'h0003, 12'hfff, 8'h00, 1'b0);
    step(16'h0005, 12'hffe, 8'h00, 1'b0);
    step(16'h0007, 12'hffe, 8'h90, 1'b0);
    step(16'h0009, 12'hffe, 8'h00, 1'b0);
    step(16'h000b, 12'hffe, 8'hb0, 1'b0);
    step(16'h000d, 12'hffe, 8'h20, 1'b0);
    step(16'h000f, 12'hffe, 8'ha0, 1'b0);
    step(16'h0010, 12'hffe, 8'h20, 1'b0);
    step(16'h0013, 12'hffd, 8'h20, 1'b0);
    step(16'h0015, 12'hffd, 8'h20, 1'b1);
    step(16'h0081, 12'hfff, 8'h20, 1'b0);
    $display("rotate and return test done");
  endtask

  // pointed rotates, zero result, extended pop and push, pointed push
  task t_pointed_stack;
    step(16'h0084, 12'hffe, 8'h20, 1'b0);
    step(16'h0086, 12'hffe, 8'h90, 1'b0);
    step(16'h0088, 12'hffe, 8'h00, 1'b0);
    step(16'h008a, 12'hffe, 8'h80, 1'b0);
    step(16'h008c, 12'hffe, 8'h00, 1'b0);
    step(16'h008f, 12'hffd, 8'h00, 1'b0);
    step(16'h0091, 12'hffd, 8'h40, 1'b0);
    step(16'h0094, 12'hffe, 8'h40, 1'b0);
    step(16'h0097, 12'hffd, 8'h40, 1'b0);
    step(16'h0099, 12'hffc, 8'h40, 1'b0);
    step(16'h009c, 12'hffb, 8'h40, 1'b0);
    step(16'h0002, 12'hffd, 8'h40, 1'b0);
    $display("pointed and stack test done");
  endtask

  // clock enable dropped in mid-push freezes the machine, then the push completes
  task t_clock_enable;
    step(16'h0003, 12'hffd, 8'h40, 1'b1);
    repeat (2) @(posedge clk);
    #1 ce = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("pm_addr", pm_addr, 16'h0005);
    chk("stack_pointer", {4'h0, stack_pointer}, 16'h0ffd);
    chk("flags", {8'h0, flags}, 16'h0040);
    chk("instr_done", {15'h0, instr_done}, 16'h0000);
    ce = 1'b1;
    step(16'h0005, 12'hffc, 8'h40, 1'b0);
    $display("clock enable test done");
  endtask

  // the whole run is some 120 cycles
  initial
  begin
    #40000;
    n_errors = n_errors + 1;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    ce = 1'b1;
    rp = 8'hff;
    n_errors = 0;
    checks_done = 0;
    t_reset();
    t_rotate_return();
    t_pointed_stack();
    t_clock_enable();
    report_and_stop();
  end
endmodule // sri_exec_bench
`default_nettype wire
